// File: src/dual_eight_bit_event_timer.sv
// two eight-bit event timers behind a classic wishbone slave
// What this block does
// - output control drives level flops, toggle, routing
// - output control takes bit and byte writes
// - reset clears output control to zero
// - set/clear command bits read back zero
// - reset sets port direction to all ones
// - interval match clears counter and raises request
// - low four select bits pick source a
// - high four select bits pick source b
// - codes six to fifteen pick prescaler taps
// - channel b uses same code mapping
// - event mode counts own external input pulses
// - event mode counts one selected edge
// - event match clears counter and raises request
// - code zero falling edge, code one rising
// - bits zero and four enable toggling
// - bits two and three set, clear flop
// - reset clears both counters to zero
`timescale 1ns/1ps
`default_nettype none
module dual_eight_bit_event_timer (
  input  wire logic        CLK,
  input  wire logic        RESET_N,
  input  wire logic        CE,
  input  wire logic        CYC_I,
  input  wire logic        STB_I,
  input  wire logic        WE_I,
  input  wire logic [7:0]  ADR_I,
  input  wire logic [31:0] DAT_I,
  input  wire logic [3:0]  SEL_I,
  output      logic [31:0] DAT_O,
  output      logic        ACK_O,
  input  wire logic        EVENT_IN_A,
  input  wire logic        EVENT_IN_B,
  input  wire logic [7:0]  PORT3_IN,
  output      logic        TIMER_OUT_A,
  output      logic        TIMER_OUT_A_OE,
  output      logic        TIMER_OUT_B,
  output      logic        TIMER_OUT_B_OE,
  output      logic        MATCH_IRQ_A,
  output      logic        MATCH_IRQ_B,
  output      logic [7:0]  PORT3_DIR,
  output      logic [7:0]  PORT3_LATCH
);
  // bus state
  logic        ack_r;     // answer flag, one cycle
  logic [31:0] rdat_r;    // read data flop
  logic        req;       // request pending, not yet answered
  logic        wr_go;     // write takes effect this edge
  logic        lane0;     // low byte lane enabled
  logic [7:0]  wbyte;     // written byte

  // software registers
  logic [7:0] source_sel_r;     // count_source_select
  logic [1:0] run_r;            // run bit per channel
  logic [7:0] out_ctrl_r;       // timer_output_control, command bits kept zero
  logic [7:0] out_ctrl_nxt;     // value after this cycle's write
  logic [7:0] cmd_bits;         // set/clear commands written this cycle
  logic [7:0] port_dir_r;       // port_three_direction
  logic [7:0] port_latch_r;     // port three output latch
  logic [7:0] match_value_a_r;  // compare value a
  logic [7:0] match_value_b_r;  // compare value b

  // counting support
  logic [timer_pkg::PRE_W-1:0] pre_r;  // free prescaler
  logic [1:0] ev_prev_r;               // last event input samples
  logic [1:0] ev_now;                  // current event inputs
  logic [1:0] tick;                    // count source pulse per channel
  logic       after_reset_r;           // low only in first cycle after release

  // pin flops
  logic       out_a_r;   // pin a value
  logic       out_b_r;   // pin b value
  logic       oe_a_r;    // pin a enable
  logic       oe_b_r;    // pin b enable

  chan_if ch[2] ();      // two channel links

  assign req   = CYC_I && STB_I && !ack_r;
  assign wr_go = CYC_I && STB_I && WE_I && ack_r;
  assign lane0 = SEL_I[0];
  assign wbyte = DAT_I[7:0];
  assign ev_now = {EVENT_IN_B, EVENT_IN_A};

  // prescaler tap decode: zero means no divider tap for this code
  function automatic logic [3:0] tap_exp(input logic [3:0] code);
    logic [3:0] e;
    e = 4'h0;
    if (code == timer_pkg::SRC_DIV4K)
      e = timer_pkg::EXP_TOP;
    else if (code >= timer_pkg::SRC_DIV4 && code <= timer_pkg::SRC_DIV1K)
      e = code - timer_pkg::EXP_OFFSET;
    return e;
  endfunction

  // tap pulse: low e bits of the prescaler all ones
  function automatic logic tap_hit(input logic [3:0] e, input logic [timer_pkg::PRE_W-1:0] pre);
    logic [timer_pkg::PRE_W-1:0] mask;
    mask = timer_pkg::PRE_W'((1 << e) - 1);
    return (e != 4'h0) && ((pre & mask) == mask);
  endfunction

  // wishbone answer: ack one cycle after the request, dropped after one cycle
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
      ack_r <= 1'b0;
    else if (CE)
      ack_r <= req;
  end
  // masked while frozen, so the master never takes an answer whose write cannot land yet
  assign ACK_O = ack_r && CE;

  // read data captured with the answer; unmapped offsets read zero
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
      rdat_r <= 32'h0000_0000;
    else if (CE && req)
    begin
      unique case (ADR_I)
        timer_pkg::OFS_SOURCE_SEL: rdat_r <= {24'h000000, source_sel_r};
        timer_pkg::OFS_RUN_CTRL:   rdat_r <= {30'h0, run_r};
        timer_pkg::OFS_OUT_CTRL,
        timer_pkg::OFS_OUT_SET,
        timer_pkg::OFS_OUT_CLR:    rdat_r <= {24'h000000, out_ctrl_r};
        timer_pkg::OFS_PORT_DIR:   rdat_r <= {24'h000000, port_dir_r};
        timer_pkg::OFS_PORT_LATCH: rdat_r <= {24'h000000, port_latch_r};
        timer_pkg::OFS_PORT_PIN:   rdat_r <= {24'h000000, PORT3_IN};
        timer_pkg::OFS_MATCH_A:    rdat_r <= {24'h000000, match_value_a_r};
        timer_pkg::OFS_MATCH_B:    rdat_r <= {24'h000000, match_value_b_r};
        timer_pkg::OFS_COUNT_A:    rdat_r <= {24'h000000, ch[0].count};
        timer_pkg::OFS_COUNT_B:    rdat_r <= {24'h000000, ch[1].count};
        default:                   rdat_r <= 32'h0000_0000;
      endcase
    end
  end
  assign DAT_O = rdat_r;

  // output control write: whole byte, or bit set / bit clear aliases
  always_comb
  begin
    out_ctrl_nxt = out_ctrl_r;
    cmd_bits = 8'h00;
    if (wr_go && lane0)
    begin
      unique case (ADR_I)
        timer_pkg::OFS_OUT_CTRL:
        begin
          out_ctrl_nxt = wbyte & ~timer_pkg::TOC_CMD_MASK;
          cmd_bits = wbyte & timer_pkg::TOC_CMD_MASK;
        end
        timer_pkg::OFS_OUT_SET:
        begin
          out_ctrl_nxt = (out_ctrl_r | wbyte) & ~timer_pkg::TOC_CMD_MASK;
          cmd_bits = wbyte & timer_pkg::TOC_CMD_MASK;
        end
        timer_pkg::OFS_OUT_CLR:
          out_ctrl_nxt = out_ctrl_r & ~wbyte;
        default:
          out_ctrl_nxt = out_ctrl_r;
      endcase
    end
  end

  // output control register; command bits never stored so they read zero
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
      out_ctrl_r <= timer_pkg::RST_ZERO;
    else if (CE)
      out_ctrl_r <= out_ctrl_nxt;
  end

  // source select and run control; codes accepted whether the channel is running or stopped
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      source_sel_r <= timer_pkg::RST_ZERO;
      run_r <= 2'b00;
    end
    else if (CE && wr_go && lane0)
    begin
      if (ADR_I == timer_pkg::OFS_SOURCE_SEL)
        source_sel_r <= wbyte;
      if (ADR_I == timer_pkg::OFS_RUN_CTRL)
        run_r <= wbyte[1:0];
    end
  end

  // compare values; hardware leaves these uncleared in spirit, zero here
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      match_value_a_r <= timer_pkg::RST_ZERO;
      match_value_b_r <= timer_pkg::RST_ZERO;
    end
    else if (CE && wr_go && lane0)
    begin
      if (ADR_I == timer_pkg::OFS_MATCH_A)
        match_value_a_r <= wbyte;
      if (ADR_I == timer_pkg::OFS_MATCH_B)
        match_value_b_r <= wbyte;
    end
  end

  // port direction and latch; all pins come up as inputs
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      port_dir_r <= timer_pkg::RST_PORT_DIR;
      port_latch_r <= timer_pkg::RST_ZERO;
    end
    else if (CE && wr_go && lane0)
    begin
      if (ADR_I == timer_pkg::OFS_PORT_DIR)
        port_dir_r <= wbyte;
      if (ADR_I == timer_pkg::OFS_PORT_LATCH)
        port_latch_r <= wbyte;
    end
  end
  assign PORT3_DIR = port_dir_r;
  assign PORT3_LATCH = port_latch_r;

  // free running prescaler, shared by both channels
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
      pre_r <= '0;
    else if (CE)
      pre_r <= pre_r + timer_pkg::PRE_W'(1);
  end

  // event input history for edge detection; inputs already synchronous
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
      ev_prev_r <= 2'b00;
    else if (CE)
      ev_prev_r <= ev_now;
  end

  // marks the first cycle after reset release
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
      after_reset_r <= 1'b0;
    else if (CE)
      after_reset_r <= 1'b1;
  end

  // per channel: source select, edge choice and control fan-out
  for (genvar i = 0; i < 2; i++)
  begin : g_chan
    logic [3:0] code; // this channel's select field
    assign code = source_sel_r[4*i +: 4];
    always_comb
    begin
      unique case (code)
        timer_pkg::SRC_FALL: tick[i] = ev_prev_r[i] && !ev_now[i];
        timer_pkg::SRC_RISE: tick[i] = !ev_prev_r[i] && ev_now[i];
        default:             tick[i] = tap_hit(tap_exp(code), pre_r);
      endcase
    end
    assign ch[i].tick = tick[i];
    assign ch[i].run = run_r[i];
    assign ch[i].toggle_en = out_ctrl_r[timer_pkg::CH_STRIDE*i + timer_pkg::TOC_TOGGLE];
    assign ch[i].lvl_set = cmd_bits[timer_pkg::CH_STRIDE*i + timer_pkg::TOC_SET];
    assign ch[i].lvl_clr = cmd_bits[timer_pkg::CH_STRIDE*i + timer_pkg::TOC_CLR];
    timer_channel u_chan (
      .clk     (CLK),
      .reset_n (RESET_N),
      .ce      (CE),
      .cb      (ch[i])
    );
  end
  assign ch[0].match_value = match_value_a_r;
  assign ch[1].match_value = match_value_b_r;
  assign MATCH_IRQ_A = ch[0].irq;
  assign MATCH_IRQ_B = ch[1].irq;

  // pins: latch ORed with routed level flop, driven while direction is output
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      out_a_r <= 1'b0;
      out_b_r <= 1'b0;
      oe_a_r <= 1'b0;
      oe_b_r <= 1'b0;
    end
    else if (CE)
    begin
      out_a_r <= port_latch_r[timer_pkg::PORT_BIT_A]
        | (out_ctrl_r[timer_pkg::TOC_OUTEN] & ch[0].level);
      out_b_r <= port_latch_r[timer_pkg::PORT_BIT_B]
        | (out_ctrl_r[timer_pkg::CH_STRIDE + timer_pkg::TOC_OUTEN] & ch[1].level);
      oe_a_r <= !port_dir_r[timer_pkg::PORT_BIT_A];
      oe_b_r <= !port_dir_r[timer_pkg::PORT_BIT_B];
    end
  end
  assign TIMER_OUT_A = out_a_r;
  assign TIMER_OUT_B = out_b_r;
  assign TIMER_OUT_A_OE = oe_a_r;
  assign TIMER_OUT_B_OE = oe_b_r;

  a_reset_values: assert property (@(posedge CLK) disable iff (!RESET_N)
    !after_reset_r |-> out_ctrl_r == timer_pkg::RST_ZERO && port_dir_r == timer_pkg::RST_PORT_DIR
      && ch[0].count == timer_pkg::COUNT_ZERO && ch[1].count == timer_pkg::COUNT_ZERO)
    else $error("reset values wrong");
  a_cmd_read_zero: assert property (@(posedge CLK) disable iff (!RESET_N)
    CE && wr_go && lane0 && ADR_I == timer_pkg::OFS_OUT_CTRL
      |=> (out_ctrl_r & timer_pkg::TOC_CMD_MASK) == 8'h00
        && out_ctrl_r == ($past(wbyte) & ~timer_pkg::TOC_CMD_MASK))
    else $error("command bits stored or byte write lost");
  a_level_set_a: assert property (@(posedge CLK) disable iff (!RESET_N)
    CE && cmd_bits[timer_pkg::TOC_SET] |=> ch[0].level)
    else $error("level set a ignored");
  a_prohibited_code: assert property (@(posedge CLK) disable iff (!RESET_N)
    source_sel_r[3:0] inside {4'h2, 4'h3, 4'h4, 4'h5} |-> !tick[0])
    else $error("prohibited code produced a tick");
  a_rise_edge_b: assert property (@(posedge CLK) disable iff (!RESET_N)
    source_sel_r[7:4] == timer_pkg::SRC_RISE && $rose(EVENT_IN_B) && $past(CE) |-> tick[1])
    else $error("rising edge missed on channel b");
  a_div4_spacing: assert property (@(posedge CLK) disable iff (!RESET_N)
    CE && source_sel_r[3:0] == timer_pkg::SRC_DIV4 && tick[0] |=> !tick[0] ##1 !tick[0] ##1 !tick[0])
    else $error("divide by four tap spacing wrong");
  a_bit_clear_alias: assert property (@(posedge CLK) disable iff (!RESET_N)
    CE && wr_go && lane0 && ADR_I == timer_pkg::OFS_OUT_CLR |=> (out_ctrl_r & $past(wbyte)) == 8'h00)
    else $error("bit clear alias failed");
  a_pin_enable: assert property (@(posedge CLK) disable iff (!RESET_N)
    CE |=> TIMER_OUT_A_OE == !$past(port_dir_r[timer_pkg::PORT_BIT_A]))
    else $error("pin enable does not follow direction");
endmodule
`default_nettype wire

// File: src/timer_pkg.sv
// constants for the dual eight-bit event timer
package timer_pkg;
  // register byte offsets on the bus
  localparam logic [7:0] OFS_SOURCE_SEL = 8'h00;
  localparam logic [7:0] OFS_RUN_CTRL   = 8'h04;
  localparam logic [7:0] OFS_OUT_CTRL   = 8'h08;
  localparam logic [7:0] OFS_OUT_SET    = 8'h0C;
  localparam logic [7:0] OFS_OUT_CLR    = 8'h10;
  localparam logic [7:0] OFS_PORT_DIR   = 8'h14;
  localparam logic [7:0] OFS_PORT_LATCH = 8'h18;
  localparam logic [7:0] OFS_PORT_PIN   = 8'h1C;
  localparam logic [7:0] OFS_MATCH_A    = 8'h20;
  localparam logic [7:0] OFS_MATCH_B    = 8'h24;
  localparam logic [7:0] OFS_COUNT_A    = 8'h28;
  localparam logic [7:0] OFS_COUNT_B    = 8'h2C;
  // reset values
  localparam logic [7:0] RST_ZERO     = 8'h00;
  localparam logic [7:0] RST_PORT_DIR = 8'hFF;
  // output control field positions, channel b adds the stride
  localparam int TOC_TOGGLE = 0;
  localparam int TOC_OUTEN  = 1;
  localparam int TOC_SET    = 2;
  localparam int TOC_CLR    = 3;
  localparam int CH_STRIDE  = 4;
  // command bits never stored
  localparam logic [7:0] TOC_CMD_MASK = 8'hCC;
  // port bit carrying each timer output
  localparam int PORT_BIT_A = 1;
  localparam int PORT_BIT_B = 2;
  // count source select codes
  localparam logic [3:0] SRC_FALL  = 4'h0;
  localparam logic [3:0] SRC_RISE  = 4'h1;
  localparam logic [3:0] SRC_DIV4  = 4'h6;
  localparam logic [3:0] SRC_DIV1K = 4'hE;
  localparam logic [3:0] SRC_DIV4K = 4'hF;
  // divider exponents: code minus this offset, last code its own
  localparam logic [3:0] EXP_OFFSET = 4'h4;
  localparam logic [3:0] EXP_TOP    = 4'hC;
  localparam int PRE_W = 12;
  localparam logic [7:0] COUNT_ZERO = 8'h00;
endpackage

// File: src/chan_if.sv
// signals between the register block and one counting channel
`timescale 1ns/1ps
`default_nettype none
interface chan_if;
  logic       tick;        // one count source pulse
  logic       run;         // channel counting
  logic       toggle_en;   // invert level flop on match
  logic       lvl_set;     // pulse, force level high
  logic       lvl_clr;     // pulse, force level low
  logic [7:0] match_value; // compare value
  logic [7:0] count;       // counter value
  logic       irq;         // match pulse
  logic       level;       // level flop
  modport ctrl (output tick, run, toggle_en, lvl_set, lvl_clr, match_value, input count, irq, level);
  modport chan (input tick, run, toggle_en, lvl_set, lvl_clr, match_value, output count, irq, level);
endinterface
`default_nettype wire

// File: src/timer_channel.sv
// one eight-bit counter with compare, match pulse and level flop
`timescale 1ns/1ps
`default_nettype none
module timer_channel (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic ce,
  chan_if.chan      cb
);
  logic [7:0] count_r; // counter
  logic       irq_r;   // match pulse
  logic       level_r; // level flop
  logic       hit;     // counter meets compare on a tick

  assign hit = cb.run && cb.tick && (count_r == cb.match_value);
  assign cb.count = count_r;
  assign cb.irq = irq_r;
  assign cb.level = level_r;

  // counter: held at zero while stopped, wraps on match
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      count_r <= timer_pkg::COUNT_ZERO;
    else if (ce)
    begin
      if (!cb.run)
        count_r <= timer_pkg::COUNT_ZERO;
      else if (hit)
        count_r <= timer_pkg::COUNT_ZERO;
      else if (cb.tick)
        count_r <= count_r + 8'h01;
    end
  end

  // one-cycle match pulse
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      irq_r <= 1'b0;
    else if (ce)
      irq_r <= hit;
  end

  // level flop: explicit set/clear beat the toggle
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      level_r <= 1'b0;
    else if (ce)
    begin
      if (cb.lvl_set)
        level_r <= 1'b1;
      else if (cb.lvl_clr)
        level_r <= 1'b0;
      else if (hit && cb.toggle_en)
        level_r <= ~level_r;
    end
  end

  a_match_clears: assert property (@(posedge clk) disable iff (!reset_n)
    ce && hit |=> count_r == timer_pkg::COUNT_ZERO && irq_r)
    else $error("match did not clear counter and raise pulse");
  a_toggle_on_hit: assert property (@(posedge clk) disable iff (!reset_n)
    ce && hit && cb.toggle_en && !cb.lvl_set && !cb.lvl_clr |=> level_r != $past(level_r))
    else $error("level flop did not toggle on match");
  a_pulse_one_cycle: assert property (@(posedge clk) disable iff (!reset_n)
    irq_r && ce && !hit |=> !irq_r)
    else $error("match pulse stretched");
endmodule
`default_nettype wire

// File: testbench/pin_partner.sv
// far-side model: event pulse sources and pulled-up port pins
`timescale 1ns/1ps
`default_nettype none
module pin_partner (
  input  wire logic       clk,
  input  wire logic [1:0] start,
  input  wire logic [3:0] width,
  input  wire logic       out_a,
  input  wire logic       oe_a,
  input  wire logic       out_b,
  input  wire logic       oe_b,
  output var  logic       ev_a,
  output var  logic       ev_b,
  output wire logic [7:0] pins
);
  logic [3:0] left = 4'h0; // cycles of pulse still to run
  initial ev_a = 1'b0;
  initial ev_b = 1'b0;
  // one pulse of the given width on the chosen lines, idle low
  always @(posedge clk)
  begin
    if (start != 2'b00)
    begin
      left <= width;
      ev_a <= start[0];
      ev_b <= start[1];
    end
    else if (left > 4'h1)
      left <= left - 4'h1;
    else
    begin
      // both edges of the pulse are seen, so either edge choice counts once
      left <= 4'h0;
      ev_a <= 1'b0;
      ev_b <= 1'b0;
    end
  end
  // undriven pins float up to the pull-up level, so a stale value never shows
  assign pins = {5'h1F, oe_b ? out_b : 1'b1, oe_a ? out_a : 1'b1, 1'b1};
endmodule
`default_nettype wire

// File: testbench/test_dual_eight_bit_event_timer.sv
// self-checking bench for the dual eight-bit event timer
`timescale 1ns/1ps
`default_nettype none
module test_dual_eight_bit_event_timer;
  logic        clk   = 1'b0;    // 100 MHz system clock
  logic        rst_n = 1'b0;    // async reset, low active
  logic        ce    = 1'b1;    // clock enable, dropped once to freeze the block
  logic        cyc   = 1'b0;    // bus cycle
  logic        stb   = 1'b0;    // bus strobe
  logic        we    = 1'b0;    // bus direction
  logic [7:0]  adr   = 8'h00;   // byte address
  logic [31:0] wdat  = 32'h0;   // write data
  logic [3:0]  sel   = 4'h0;    // byte lanes
  logic [1:0]  start = 2'b00;   // pulse request to the partner
  logic [3:0]  width = 4'hC;    // pulse width in cycles
  wire  logic [31:0] dat_o;     // read data
  wire  logic        ack;       // bus answer
  wire  logic        ev_a;      // event line a
  wire  logic        ev_b;      // event line b
  wire  logic [7:0]  pins;      // resolved port pins
  wire  logic        out_a;     // timer pin a
  wire  logic        oe_a;      // pin a driven
  wire  logic        out_b;     // timer pin b
  wire  logic        oe_b;      // pin b driven
  wire  logic [1:0]  irq;       // match pulses b,a
  wire  logic [7:0]  dir;       // port direction
  wire  logic [7:0]  latch;     // port output latch
  int err_count  = 0;           // mismatches
  int n_compared = 0;           // comparisons made
  int now = 0;                  // cycle count
  int n_irq[2]  = '{0, 0};      // match pulses seen
  int t_last[2] = '{0, 0};      // cycle of last pulse
  int t_prev[2] = '{0, 0};      // cycle of pulse before

  dual_eight_bit_event_timer DUT (
    .CLK(clk), .RESET_N(rst_n), .CE(ce), .CYC_I(cyc), .STB_I(stb), .WE_I(we), .ADR_I(adr),
    .DAT_I(wdat), .SEL_I(sel), .DAT_O(dat_o), .ACK_O(ack), .EVENT_IN_A(ev_a), .EVENT_IN_B(ev_b),
    .PORT3_IN(pins), .TIMER_OUT_A(out_a), .TIMER_OUT_A_OE(oe_a), .TIMER_OUT_B(out_b),
    .TIMER_OUT_B_OE(oe_b), .MATCH_IRQ_A(irq[0]), .MATCH_IRQ_B(irq[1]), .PORT3_DIR(dir),
    .PORT3_LATCH(latch));
  pin_partner far_side (
    .clk(clk), .start(start), .width(width), .out_a(out_a), .oe_a(oe_a), .out_b(out_b),
    .oe_b(oe_b), .ev_a(ev_a), .ev_b(ev_b), .pins(pins));

  always #5 clk = ~clk;
  // timestamp every match pulse per channel
  always @(posedge clk)
  begin
    now++;
    for (int c = 0; c < 2; c++)
      if (irq[c] === 1'b1)
      begin
        n_irq[c]++;
        t_prev[c] = t_last[c];
        t_last[c] = now;
      end
  end

  task finish_test;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      err_count++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // classic single cycle; waits for ack with a bounded count
  task bus(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    int i;
    @(posedge clk);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= {24'h0, d}; sel <= 4'hF;
    for (i = 0; i < 16; i++)
    begin
      @(posedge clk);
      if (ack === 1'b1)
        break;
    end
    q = dat_o[7:0];
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    if (i == 16)
    begin
      err_count++;
      $display("BAD %0t no bus answer", $time);
      finish_test();
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, a, d, q);
  endtask
  task rchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] q;
    bus(1'b0, a, 8'h00, q);
    check({24'h0, q}, {24'h0, e});
  endtask
  task wait_irq(input int c, input int cnt);
    for (int i = 0; i < 30000 && n_irq[c] < cnt; i++)
      @(posedge clk);
    if (n_irq[c] < cnt)
    begin
      err_count++;
      $display("BAD %0t match pulse missing", $time);
      finish_test();
    end
  endtask

  task t_reset;
    rchk(timer_pkg::OFS_OUT_CTRL, 8'h00);
    rchk(timer_pkg::OFS_PORT_DIR, 8'hFF);
    check({16'h0, dir, latch}, 32'hFF00);
    rchk(timer_pkg::OFS_COUNT_A, 8'h00);
    rchk(timer_pkg::OFS_COUNT_B, 8'h00);
    rchk(8'h30, 8'h00);
    check({30'h0, oe_b, oe_a}, 32'h0);
    $display("test reset done");
  endtask
  // level flops set by a byte write, cleared by bit set alias writes
  task t_levels;
    wr(timer_pkg::OFS_RUN_CTRL, 8'h00);
    wr(timer_pkg::OFS_PORT_DIR, 8'hF9);
    wr(timer_pkg::OFS_PORT_LATCH, 8'h00);
    wr(timer_pkg::OFS_OUT_CTRL, 8'h66);
    rchk(timer_pkg::OFS_OUT_CTRL, 8'h22);
    repeat (3) @(posedge clk);
    check({28'h0, oe_b, oe_a, out_b, out_a}, 32'hF);
    rchk(timer_pkg::OFS_PORT_PIN, 8'hFF);
    wr(timer_pkg::OFS_OUT_SET, 8'h08);
    repeat (3) @(posedge clk);
    check({30'h0, out_b, out_a}, 32'h2);
    rchk(timer_pkg::OFS_PORT_PIN, 8'hFD);
    wr(timer_pkg::OFS_OUT_SET, 8'h80);
    wr(timer_pkg::OFS_OUT_CLR, 8'h20);
    rchk(timer_pkg::OFS_OUT_CTRL, 8'h02);
    repeat (3) @(posedge clk);
    check({31'h0, out_b}, 32'h0);
    $display("test levels done");
  endtask
  // every prescaler code on both channels, two compare values
  task t_interval;
    int e;
    int want_a;
    int want_b;
    for (int c = 6; c < 16; c++)
    begin
      wr(timer_pkg::OFS_RUN_CTRL, 8'h00);
      wr(timer_pkg::OFS_SOURCE_SEL, {c[3:0], c[3:0]});
      wr(timer_pkg::OFS_MATCH_A, 8'h01);
      wr(timer_pkg::OFS_MATCH_B, 8'h00);
      wr(timer_pkg::OFS_RUN_CTRL, 8'h03);
      // both targets fixed first so the two channels are waited for together
      want_a = n_irq[0] + 3;
      want_b = n_irq[1] + 3;
      wait_irq(0, want_a);
      wait_irq(1, want_b);
      e = (c == 15) ? 12 : c - 4;
      check(t_last[0] - t_prev[0], 2 << e);
      check(t_last[1] - t_prev[1], 1 << e);
    end
    $display("test interval done");
  endtask
  // toggling on match, top compare value, prohibited codes
  task t_toggle;
    logic v;
    int base;
    wr(timer_pkg::OFS_RUN_CTRL, 8'h00);
    wr(timer_pkg::OFS_OUT_CTRL, 8'h0B);
    wr(timer_pkg::OFS_SOURCE_SEL, 8'h66);
    wr(timer_pkg::OFS_MATCH_A, 8'h03);
    wr(timer_pkg::OFS_MATCH_B, 8'hFF);
    wr(timer_pkg::OFS_RUN_CTRL, 8'h03);
    wait_irq(0, n_irq[0] + 1);
    repeat (4) @(posedge clk);
    v = out_a;
    wait_irq(0, n_irq[0] + 1);
    repeat (4) @(posedge clk);
    check({31'h0, out_a}, {31'h0, ~v});
    // clock enable low: a runs every 16 cycles, so 100 frozen cycles must bring no pulse
    base = n_irq[0];
    ce <= 1'b0;
    repeat (100) @(posedge clk);
    check(n_irq[0] - base, 0);
    ce <= 1'b1;
    wait_irq(1, n_irq[1] + 2);
    check(t_last[1] - t_prev[1], 1024);
    wr(timer_pkg::OFS_RUN_CTRL, 8'h00);
    wr(timer_pkg::OFS_SOURCE_SEL, 8'h25);
    wr(timer_pkg::OFS_RUN_CTRL, 8'h03);
    v = 1'b0;
    repeat (300) @(posedge clk);
    rchk(timer_pkg::OFS_COUNT_A, 8'h00);
    rchk(timer_pkg::OFS_COUNT_B, 8'h00);
    $display("test toggle done");
  endtask
  // pass 0: rising on a, falling on b; pass 1 swaps the edges; match at two
  task t_event;
    int k;
    int base;
    logic [7:0] early_a;
    logic [7:0] early_b;
    for (int p = 0; p < 2; p++)
    begin
      wr(timer_pkg::OFS_RUN_CTRL, 8'h00);
      wr(timer_pkg::OFS_SOURCE_SEL, (p != 0) ? 8'h10 : 8'h01);
      wr(timer_pkg::OFS_MATCH_A, 8'h02);
      wr(timer_pkg::OFS_MATCH_B, 8'h02);
      wr(timer_pkg::OFS_RUN_CTRL, 8'h03);
      base = n_irq[0] + n_irq[1];
      for (k = 1; k < 4; k++)
      begin
        // the rising channel has counted already, the falling one not yet
        early_a = 8'((p != 0) ? k - 1 : k % 3);
        early_b = 8'((p != 0) ? k % 3 : k - 1);
        @(posedge clk);
        start <= 2'b11;
        @(posedge clk);
        start <= 2'b00;
        @(posedge clk);
        rchk(timer_pkg::OFS_COUNT_A, early_a);
        rchk(timer_pkg::OFS_COUNT_B, early_b);
        repeat (12) @(posedge clk);
        rchk(timer_pkg::OFS_COUNT_A, 8'(k % 3));
        rchk(timer_pkg::OFS_COUNT_B, 8'(k % 3));
      end
      check(n_irq[0] + n_irq[1] - base, 2);
    end
    $display("test event done");
  endtask

  initial
  begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_levels();
    t_interval();
    t_toggle();
    t_event();
    finish_test();
  end
endmodule
`default_nettype wire
